// ### include/asi_seq_regs.vh
// Purpose: Register offsets, fields, reset values and codes of the sequencer
// Assumes: Byte addresses on a 6-bit register port, 32-bit data
// Notes: Slave index 0..31 is the A range, 32..63 the B range
`ifndef ASI_SEQ_REGS_VH
`define ASI_SEQ_REGS_VH

`define REG_CTRL 6'h00
`define REG_STATUS 6'h04
`define REG_LDS_LO 6'h08
`define REG_LDS_HI 6'h0c
`define REG_LAS_LO 6'h10
`define REG_LAS_HI 6'h14
`define REG_LPS_LO 6'h18
`define REG_LPS_HI 6'h1c
`define REG_HOST_CMD 6'h20
`define REG_ACT_PARAM 6'h24
`define REG_SEL 6'h28
`define REG_READBACK 6'h2c
`define REG_PROJ 6'h30
`define REG_OUT_IMG 6'h34
`define REG_IN_IMG 6'h38

`define CTRL_OFFLINE 0
`define CTRL_CONFIG 1
`define CTRL_AUTO 2
`define CTRL_RST 3'h1

`define HOST_OLD_LSB 0
`define HOST_NEW_LSB 8

`define CMD_DATA 3'h0
`define CMD_PARAM 3'h1
`define CMD_RD_IO 3'h2
`define CMD_ADDR 3'h6

`define OUT_DEFAULT 4'hf
`define IN_DEFAULT 4'h0
`define ACT_PARAM_RST 4'hf
`define MISS_LIMIT 2'h3
`define PROJ_EN_BIT 7
`define IDX_LAST 6'h3f
`define IDX_B_ZERO 6'h20
`define INCL_CHECK 3'h4
`define INCL_DATA 3'h5
`define SLOT_MASK 64'hfffffffefffffffe

`endif

// ### hw/free_addr_finder.v
// Purpose: Lowest operating address not taken in a slave list
// Assumes: Index 0 and index 32 are never operating addresses
// Notes: Search runs B range first, then A range; the last free index found wins
`timescale 1ns/1ps
module free_addr_finder (
	input wire [63:0] used,
	output reg found,
	output reg [5:0] idx
);
	integer i;
	always @* begin
		found = 1'b0;
		idx = 6'h00;
		for (i = 63; i > 0; i = i - 1) begin
			if (!used[i] && i != 32) begin
				found = 1'b1;
				idx = i[5:0];
			end
		end
	end
endmodule // free_addr_finder

// ### hw/list_checker.v
// Purpose: Compare detected and projected lists
// Assumes: Lists hold one bit per slave index
// Notes: Address 0 and 0B are masked out of every comparison
`timescale 1ns/1ps
`include "asi_seq_regs.vh"
module list_checker (
	input wire [63:0] detected_slave_list,
	input wire [63:0] projected_slave_list,
	output wire one_missing,
	output reg [5:0] missing_idx,
	output wire unprojected,
	output wire fault
);
	wire [63:0] miss;
	wire [63:0] extra;
	integer i;
	assign miss = projected_slave_list & ~detected_slave_list & `SLOT_MASK;
	assign extra = detected_slave_list & ~projected_slave_list & `SLOT_MASK;
	assign one_missing = (miss != 64'h0) && ((miss & (miss - 64'h1)) == 64'h0);
	assign unprojected = (extra != 64'h0);
	assign fault = (miss != 64'h0) || unprojected;
	always @* begin
		missing_idx = 6'h00;
		for (i = 0; i < 64; i = i + 1) begin
			if (miss[i])
				missing_idx = i[5:0];
		end
	end
endmodule // list_checker

// ### hw/asi_phase_sequencer.v
// Purpose: Operating phase sequencer of a bus master for A/B-addressed slaves
// Assumes: Link layer on sys_clk answers every command with one resp_done
// Notes: Registers on a plain port, read data valid one cycle after read
// Notes on behaviour
// - After reset sit offline and send nothing to any slave.
// - Host offline flag forces outputs to 1, inputs to 0, stops commands.
// - Detection reads I/O id, id code, both extended ids into storage.
// - Found slaves enter detected list; activation needs one detected slave.
// - Protected mode activates only slaves marked projected.
// - Configuration mode: parameter call with activation value, data all ones.
// - Activated slaves marked in activated list; then data exchange.
// - Three missed exchanges drop slave from both lists, inputs zero.
// - After one full data cycle enter management.
// - Management sends one command only for auto address or host request.
// - Inclusion sends one command; new slave steps spread over cycles.
// - Address 0 never exchanges data; new slaves probed at 0.
// - B addresses 1B to 31B supported, 0B rejected.
// - Host address change goes straight from old to new address, no slave at 0 needed.
// - Configuration mode auto addressing uses lowest free address.
// - Protected auto addressing: one projected missing, none unprojected.
// - Projected id compared only when its bit 7 enable is set.
// - No reply to inclusion probe starts data exchange at once.
// - Protected mode flags unprojected or missing slaves to the host.
`timescale 1ns/1ps
`include "asi_seq_regs.vh"
module asi_phase_sequencer (
	input wire sys_clk,
	input wire srst,
	input wire [5:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	output reg cmd_valid,
	output reg [2:0] cmd_type,
	output reg [5:0] cmd_addr,
	output reg [5:0] cmd_data,
	input wire resp_done,
	input wire resp_ok,
	input wire [3:0] resp_data,
	output reg config_fault,
	output reg offline_active
);
	localparam ST_OFF = 6'b000001;
	localparam ST_DET = 6'b000010;
	localparam ST_ACT = 6'b000100;
	localparam ST_EXC = 6'b001000;
	localparam ST_MGT = 6'b010000;
	localparam ST_INC = 6'b100000;

	reg [5:0] state_reg;
	reg [5:0] idx_reg;
	reg [2:0] step_reg;
	reg wait_reg;
	reg [5:0] incl_addr_reg;
	reg [2:0] incl_step_reg;
	reg mgt_host_reg;
	reg zero_seen_reg;
	reg [2:0] ctrl_reg;
	reg [63:0] lds_reg;
	reg [63:0] las_reg;
	reg [63:0] lps_reg;
	reg [13:0] host_cmd_reg;
	reg host_pend_reg;
	reg host_ok_reg;
	reg [3:0] act_param_reg;
	reg [5:0] sel_reg;
	reg [15:0] rb_mem [0:63];
	reg [31:0] proj_mem [0:63];
	reg [3:0] out_mem [0:63];
	reg [3:0] in_mem [0:63];
	reg [1:0] miss_mem [0:63];
	reg [31:0] rdata_next;
	integer i;

	wire cfg_mode;
	wire free_found;
	wire [5:0] free_idx;
	wire one_missing;
	wire [5:0] missing_idx;
	wire unprojected;
	wire fault;
	wire auto_go;
	wire [5:0] auto_target;
	wire act_ok;
	wire incl_ok;

	// Disabled fields always match, so partial projection stays usable
	function id_match;
		input [31:0] proj;
		input [15:0] rb;
		integer k;
		begin
			id_match = 1'b1;
			for (k = 0; k < 4; k = k + 1) begin
				if (proj[8 * k + `PROJ_EN_BIT] &&
					proj[8 * k +: 4] != rb[4 * k +: 4])
					id_match = 1'b0;
			end
		end
	endfunction

	// Skips 0B so it is never addressed
	function [5:0] next_idx;
		input [5:0] cur;
		begin
			if (cur == `IDX_B_ZERO - 6'h01)
				next_idx = `IDX_B_ZERO + 6'h01;
			else
				next_idx = cur + 6'h01;
		end
	endfunction

	free_addr_finder u_free (
		.used(lds_reg),
		.found(free_found),
		.idx(free_idx)
	);

	list_checker u_check (
		.detected_slave_list(lds_reg),
		.projected_slave_list(lps_reg),
		.one_missing(one_missing),
		.missing_idx(missing_idx),
		.unprojected(unprojected),
		.fault(fault)
	);

	assign cfg_mode = ctrl_reg[`CTRL_CONFIG];
	assign auto_go = ctrl_reg[`CTRL_AUTO] && zero_seen_reg &&
		(cfg_mode ? free_found : (one_missing && !unprojected));
	assign auto_target = cfg_mode ? free_idx : missing_idx;
	assign act_ok = lds_reg[idx_reg] && (cfg_mode ||
		(lps_reg[idx_reg] && id_match(proj_mem[idx_reg], rb_mem[idx_reg])));
	assign incl_ok = cfg_mode || (lps_reg[incl_addr_reg] &&
		id_match(proj_mem[incl_addr_reg], rb_mem[incl_addr_reg]));

	always @* begin
		case (reg_addr)
		`REG_CTRL: rdata_next = {29'h0, ctrl_reg};
		`REG_STATUS: rdata_next = {20'h0, zero_seen_reg, host_ok_reg,
			host_pend_reg, config_fault, 2'h0, state_reg};
		`REG_LDS_LO: rdata_next = lds_reg[31:0];
		`REG_LDS_HI: rdata_next = lds_reg[63:32];
		`REG_LAS_LO: rdata_next = las_reg[31:0];
		`REG_LAS_HI: rdata_next = las_reg[63:32];
		`REG_LPS_LO: rdata_next = lps_reg[31:0];
		`REG_LPS_HI: rdata_next = lps_reg[63:32];
		`REG_HOST_CMD: rdata_next = {18'h0, host_cmd_reg};
		`REG_ACT_PARAM: rdata_next = {28'h0, act_param_reg};
		`REG_SEL: rdata_next = {26'h0, sel_reg};
		`REG_READBACK: rdata_next = {16'h0, rb_mem[sel_reg]};
		`REG_PROJ: rdata_next = proj_mem[sel_reg];
		`REG_OUT_IMG: rdata_next = {28'h0, out_mem[sel_reg]};
		`REG_IN_IMG: rdata_next = {28'h0, in_mem[sel_reg]};
		default: rdata_next = 32'h0;
		endcase
	end

	always @(posedge sys_clk) begin
		if (srst) begin
			state_reg <= ST_OFF;
			idx_reg <= 6'h01;
			step_reg <= 3'h0;
			wait_reg <= 1'b0;
			incl_addr_reg <= 6'h00;
			incl_step_reg <= 3'h0;
			mgt_host_reg <= 1'b0;
			zero_seen_reg <= 1'b0;
			ctrl_reg <= `CTRL_RST;
			lds_reg <= 64'h0;
			las_reg <= 64'h0;
			lps_reg <= 64'h0;
			host_cmd_reg <= 14'h0;
			host_pend_reg <= 1'b0;
			host_ok_reg <= 1'b0;
			act_param_reg <= `ACT_PARAM_RST;
			sel_reg <= 6'h00;
			reg_rdata <= 32'h0;
			cmd_valid <= 1'b0;
			cmd_type <= 3'h0;
			cmd_addr <= 6'h00;
			cmd_data <= 6'h00;
			config_fault <= 1'b0;
			offline_active <= 1'b1;
			for (i = 0; i < 64; i = i + 1) begin
				rb_mem[i] <= 16'h0;
				proj_mem[i] <= 32'h0;
				out_mem[i] <= `OUT_DEFAULT;
				in_mem[i] <= `IN_DEFAULT;
				miss_mem[i] <= 2'h0;
			end
		end else begin
			cmd_valid <= 1'b0;
			reg_rdata <= reg_rd ? rdata_next : 32'h0;
			config_fault <= !cfg_mode && fault;
			offline_active <= (state_reg == ST_OFF);
			if (reg_wr) begin
				case (reg_addr)
				`REG_CTRL: ctrl_reg <= reg_wdata[2:0];
				`REG_LPS_LO: lps_reg[31:0] <= reg_wdata & 32'hfffffffe;
				`REG_LPS_HI: lps_reg[63:32] <= reg_wdata & 32'hfffffffe;
				`REG_ACT_PARAM: act_param_reg <= reg_wdata[3:0];
				`REG_SEL: sel_reg <= reg_wdata[5:0];
				`REG_PROJ: proj_mem[sel_reg] <= reg_wdata;
				`REG_OUT_IMG: out_mem[sel_reg] <= reg_wdata[3:0];
				default: ;
				endcase
			end
			if (ctrl_reg[`CTRL_OFFLINE] && state_reg != ST_OFF) begin
				state_reg <= ST_OFF;
				wait_reg <= 1'b0;
				for (i = 0; i < 64; i = i + 1) begin
					if (las_reg[i]) begin
						out_mem[i] <= `OUT_DEFAULT;
						in_mem[i] <= `IN_DEFAULT;
					end
				end
			end else begin
				case (state_reg)
				ST_OFF: begin
					if (!ctrl_reg[`CTRL_OFFLINE]) begin
						state_reg <= ST_DET;
						idx_reg <= 6'h01;
						step_reg <= 3'h0;
						lds_reg <= 64'h0;
						las_reg <= 64'h0;
						// A half-done inclusion must not resume under a new mode
						incl_step_reg <= 3'h0;
					end
				end
				ST_DET: begin
					if (!wait_reg) begin
						cmd_valid <= 1'b1;
						cmd_type <= `CMD_RD_IO + step_reg;
						cmd_addr <= idx_reg;
						cmd_data <= 6'h00;
						wait_reg <= 1'b1;
					end else if (resp_done) begin
						wait_reg <= 1'b0;
						if (resp_ok)
							rb_mem[idx_reg][4 * step_reg +: 4] <= resp_data;
						if (resp_ok && step_reg != 3'h3) begin
							step_reg <= step_reg + 3'h1;
						end else begin
							step_reg <= 3'h0;
							if (resp_ok)
								lds_reg[idx_reg] <= 1'b1;
							if (idx_reg == `IDX_LAST) begin
								idx_reg <= 6'h01;
								if (lds_reg != 64'h0 || resp_ok)
									state_reg <= ST_ACT;
							end else begin
								idx_reg <= next_idx(idx_reg);
							end
						end
					end
				end
				ST_ACT: begin
					if (!act_ok && !wait_reg) begin
						idx_reg <= next_idx(idx_reg);
						if (idx_reg == `IDX_LAST) begin
							idx_reg <= 6'h01;
							state_reg <= ST_EXC;
						end
					end else if (!wait_reg) begin
						cmd_valid <= 1'b1;
						cmd_addr <= idx_reg;
						wait_reg <= 1'b1;
						if (step_reg == 3'h0) begin
							cmd_type <= `CMD_PARAM;
							cmd_data <= {2'h0, act_param_reg};
						end else begin
							cmd_type <= `CMD_DATA;
							cmd_data <= {2'h0, `OUT_DEFAULT};
							out_mem[idx_reg] <= `OUT_DEFAULT;
						end
					end else if (resp_done) begin
						wait_reg <= 1'b0;
						if (step_reg == 3'h0) begin
							step_reg <= 3'h1;
						end else begin
							step_reg <= 3'h0;
							las_reg[idx_reg] <= resp_ok;
							miss_mem[idx_reg] <= 2'h0;
							if (idx_reg == `IDX_LAST) begin
								idx_reg <= 6'h01;
								state_reg <= ST_EXC;
							end else begin
								idx_reg <= next_idx(idx_reg);
							end
						end
					end
				end
				ST_EXC: begin
					if (!wait_reg && !las_reg[idx_reg]) begin
						if (idx_reg == `IDX_LAST) begin
							idx_reg <= 6'h01;
							state_reg <= ST_MGT;
						end else begin
							idx_reg <= next_idx(idx_reg);
						end
					end else if (!wait_reg) begin
						cmd_valid <= 1'b1;
						cmd_type <= `CMD_DATA;
						cmd_addr <= idx_reg;
						cmd_data <= {2'h0, out_mem[idx_reg]};
						wait_reg <= 1'b1;
					end else if (resp_done) begin
						wait_reg <= 1'b0;
						if (resp_ok) begin
							in_mem[idx_reg] <= resp_data;
							miss_mem[idx_reg] <= 2'h0;
						end else if (miss_mem[idx_reg] == `MISS_LIMIT - 2'h1) begin
							las_reg[idx_reg] <= 1'b0;
							lds_reg[idx_reg] <= 1'b0;
							in_mem[idx_reg] <= `IN_DEFAULT;
							miss_mem[idx_reg] <= 2'h0;
						end else begin
							miss_mem[idx_reg] <= miss_mem[idx_reg] + 2'h1;
						end
						if (idx_reg == `IDX_LAST) begin
							idx_reg <= 6'h01;
							state_reg <= ST_MGT;
						end else begin
							idx_reg <= next_idx(idx_reg);
						end
					end
				end
				ST_MGT: begin
					if (!wait_reg) begin
						if (host_pend_reg || auto_go) begin
							cmd_valid <= 1'b1;
							cmd_type <= `CMD_ADDR;
							wait_reg <= 1'b1;
							mgt_host_reg <= host_pend_reg;
							// Auto path success relies on a single slave sitting at 0
							cmd_addr <= host_pend_reg ?
								host_cmd_reg[`HOST_OLD_LSB +: 6] : 6'h00;
							cmd_data <= host_pend_reg ?
								host_cmd_reg[`HOST_NEW_LSB +: 6] : auto_target;
						end else begin
							state_reg <= ST_INC;
						end
					end else if (resp_done) begin
						wait_reg <= 1'b0;
						state_reg <= ST_INC;
						if (mgt_host_reg) begin
							host_pend_reg <= 1'b0;
							host_ok_reg <= resp_ok;
						end else if (resp_ok) begin
							zero_seen_reg <= 1'b0;
						end
					end
				end
				ST_INC: begin
					if (!wait_reg) begin
						// Only a fresh address is skipped when taken: the slave's own
						// detected bit is set after the fourth of its six inclusion steps
						if ((incl_addr_reg != 6'h00 && incl_step_reg == 3'h0 &&
							lds_reg[incl_addr_reg]) ||
							incl_addr_reg == `IDX_B_ZERO ||
							(incl_step_reg == `INCL_CHECK && !incl_ok)) begin
							// Taken, illegal or rejected: move on without a command
							incl_step_reg <= 3'h0;
							incl_addr_reg <= (incl_addr_reg == `IDX_LAST) ?
								6'h00 : incl_addr_reg + 6'h01;
							state_reg <= ST_EXC;
						end else begin
							cmd_valid <= 1'b1;
							cmd_addr <= incl_addr_reg;
							wait_reg <= 1'b1;
							if (incl_step_reg == `INCL_CHECK) begin
								cmd_type <= `CMD_PARAM;
								cmd_data <= {2'h0, act_param_reg};
							end else if (incl_step_reg == `INCL_DATA) begin
								cmd_type <= `CMD_DATA;
								cmd_data <= {2'h0, `OUT_DEFAULT};
								out_mem[incl_addr_reg] <= `OUT_DEFAULT;
							end else begin
								cmd_type <= `CMD_RD_IO + incl_step_reg;
								cmd_data <= 6'h00;
							end
						end
					end else if (resp_done) begin
						wait_reg <= 1'b0;
						state_reg <= ST_EXC;
						if (incl_addr_reg == 6'h00) begin
							zero_seen_reg <= resp_ok;
							incl_addr_reg <= 6'h01;
						end else if (!resp_ok || incl_step_reg == `INCL_DATA) begin
							if (resp_ok) begin
								las_reg[incl_addr_reg] <= 1'b1;
								miss_mem[incl_addr_reg] <= 2'h0;
							end
							incl_step_reg <= 3'h0;
							incl_addr_reg <= (incl_addr_reg == `IDX_LAST) ?
								6'h00 : incl_addr_reg + 6'h01;
						end else begin
							if (incl_step_reg < `INCL_CHECK)
								rb_mem[incl_addr_reg][4 * incl_step_reg +: 4] <=
									resp_data;
							if (incl_step_reg == `INCL_CHECK - 3'h1)
								lds_reg[incl_addr_reg] <= 1'b1;
							incl_step_reg <= incl_step_reg + 3'h1;
						end
					end
				end
				default: state_reg <= ST_OFF;
				endcase
			end
			// Host write after the sequencer clear, so a new request wins
			if (reg_wr && reg_addr == `REG_HOST_CMD) begin
				host_cmd_reg <= reg_wdata[13:0];
				host_pend_reg <= 1'b1;
			end
		end
	end
endmodule // asi_phase_sequencer

// ### tb/asi_slave_model.sv
// Purpose: Behavioural set of bus slaves answering the sequencer
// Assumes: One command outstanding, answer after a short or long wait
// Notes: Reply nibble is index xor command code, so reads are predictable
`timescale 1ns/1ps
`include "asi_seq_regs.vh"
module asi_slave_model (
	input wire sys_clk,
	input wire srst,
	input wire cmd_valid,
	input wire [2:0] cmd_type,
	input wire [5:0] cmd_addr,
	input wire [5:0] cmd_data,
	input wire slow,
	output reg resp_done = 1'b0,
	output reg resp_ok = 1'b0,
	output reg [3:0] resp_data = 4'h0
);
	reg [63:0] present = 64'h0;
	reg busy = 1'b0;
	reg [3:0] wait_cnt = 4'h0;
	reg [5:0] addr_q = 6'h0;
	reg [5:0] data_q = 6'h0;
	reg [2:0] type_q = 3'h0;
	always @(posedge sys_clk) begin
		resp_done <= 1'b0;
		// Reply lines are not held between answers
		resp_ok <= ~resp_ok;
		resp_data <= ~resp_data;
		if (srst) begin
			busy <= 1'b0;
		end else if (cmd_valid) begin
			busy <= 1'b1;
			wait_cnt <= slow ? 4'h6 : 4'h1;
			addr_q <= cmd_addr;
			type_q <= cmd_type;
			data_q <= cmd_data;
		end else if (busy && wait_cnt != 4'h0) begin
			wait_cnt <= wait_cnt - 4'h1;
		end else if (busy) begin
			busy <= 1'b0;
			resp_done <= 1'b1;
			resp_ok <= present[addr_q];
			resp_data <= addr_q[3:0] ^ {1'b0, type_q};
			// Only one slave sits at the old index, so the move is unique
			if (type_q == `CMD_ADDR && present[addr_q]) begin
				present[addr_q] <= 1'b0;
				present[data_q] <= 1'b1;
			end
		end
	end
endmodule // asi_slave_model

// ### tb/asi_phase_sequencer_properties.sv
// Purpose: Port-level properties of the phase sequencer
// Assumes: Single clock, synchronous reset
// Notes: Bound into the sequencer below
`timescale 1ns/1ps
`include "asi_seq_regs.vh"
module asi_seq_checker (
	input wire sys_clk,
	input wire srst,
	input wire [5:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	input wire cmd_valid,
	input wire [2:0] cmd_type,
	input wire [5:0] cmd_addr,
	input wire resp_done,
	input wire config_fault,
	input wire offline_active
);
	reg pend_reg;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	// One command in flight: set by a command, cleared by its answer
	always @(posedge sys_clk) begin
		if (srst)
			pend_reg <= 1'b0;
		else if (cmd_valid)
			pend_reg <= 1'b1;
		else if (resp_done)
			pend_reg <= 1'b0;
	end
	a_reset_offline: assert property ($fell(srst)
		|-> offline_active)
		else $error("not offline after reset");
	a_offline_silent: assert property (offline_active
		|-> !cmd_valid)
		else $error("command sent while offline");
	a_offline_go: assert property ((reg_wr &&
		reg_addr == `REG_CTRL && reg_wdata[`CTRL_OFFLINE])
		|-> ##[1:4] offline_active)
		else $error("offline request not obeyed");
	a_one_cmd: assert property (cmd_valid |-> !pend_reg)
		else $error("second command before answer");
	a_no_zero_data: assert property ((cmd_valid &&
		cmd_type == `CMD_DATA) |-> cmd_addr[4:0] != 5'h0)
		else $error("data call to address 0 or 0B");
	a_fault_cfg: assert property ((reg_wr &&
		reg_addr == `REG_CTRL && reg_wdata[`CTRL_CONFIG])
		|-> ##3 !config_fault)
		else $error("fault flag outside protected mode");
	a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data without read");
	a_unmapped_zero: assert property ((reg_rd && reg_addr == 6'h3c)
		|=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_ctrl_back: assert property ((reg_wr && reg_addr == `REG_CTRL) ##2
		(reg_rd && reg_addr == `REG_CTRL)
		|=> reg_rdata[2:0] == $past(reg_wdata[2:0], 3))
		else $error("control readback wrong");
endmodule // asi_seq_checker
bind asi_phase_sequencer asi_seq_checker asi_seq_checker_inst (.sys_clk,
	.srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cmd_valid,
	.cmd_type, .cmd_addr, .resp_done, .config_fault, .offline_active);

// ### tb/asi_phase_sequencer_tb.sv
// Purpose: Self-checking bench of the phase sequencer
// Assumes: Slave model answers every command
// Notes: Waits poll registers with a bound, never open-ended
`timescale 1ns/1ps
`include "asi_seq_regs.vh"
module asi_phase_sequencer_tb;
	reg sys_clk = 1'b0;
	reg srst = 1'b1;
	reg [5:0] reg_addr = 6'h0;
	reg [31:0] reg_wdata = 32'h0;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	reg slow = 1'b1;
	wire [31:0] reg_rdata;
	wire cmd_valid, resp_done, resp_ok, config_fault, offline_active;
	wire [2:0] cmd_type;
	wire [5:0] cmd_addr, cmd_data;
	wire [3:0] resp_data;
	integer fails = 0;
	integer comparisons = 0;
	integer ncmd = 0;
	integer snap = 0;
	reg [31:0] d;
	always #10 sys_clk = ~sys_clk;
	asi_phase_sequencer asi_phase_sequencer_inst (.sys_clk(sys_clk),
		.srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cmd_valid(cmd_valid), .cmd_type(cmd_type), .cmd_addr(cmd_addr),
		.cmd_data(cmd_data), .resp_done(resp_done), .resp_ok(resp_ok),
		.resp_data(resp_data), .config_fault(config_fault),
		.offline_active(offline_active));
	asi_slave_model asi_slave_model_inst (.sys_clk(sys_clk), .srst(srst),
		.cmd_valid(cmd_valid), .cmd_type(cmd_type), .cmd_addr(cmd_addr),
		.cmd_data(cmd_data), .slow(slow), .resp_done(resp_done),
		.resp_ok(resp_ok), .resp_data(resp_data));
	task end_sim;
		begin
			$display("fails=%0d comparisons=%0d", fails, comparisons);
			if (fails == 0 && comparisons > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				fails = fails + 1;
				$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task wr(input [5:0] a, input [31:0] v);
		begin
			@(posedge sys_clk);
			reg_addr <= a;
			reg_wdata <= v;
			reg_wr <= 1'b1;
			@(posedge sys_clk);
			reg_wr <= 1'b0;
		end
	endtask
	// Data stand only in the cycle after the strobe, so sample just past it
	task rd(input [5:0] a, output [31:0] v);
		begin
			@(posedge sys_clk);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge sys_clk);
			reg_rd <= 1'b0;
			#1 v = reg_rdata;
		end
	endtask
	task rchk(input [5:0] a, input [31:0] m, input [31:0] exp);
		begin
			rd(a, d);
			chk(d & m, exp);
		end
	endtask
	task poll(input [5:0] a, input [31:0] m, input [31:0] exp);
		integer i;
		begin
			i = 0;
			rd(a, d);
			while ((d & m) !== exp && i < 6000) begin
				rd(a, d);
				i = i + 1;
			end
			chk(d & m, exp);
			if (i >= 6000)
				end_sim;
		end
	endtask
	always @(negedge sys_clk) begin
		if (cmd_valid === 1'b1) begin
			ncmd = ncmd + 1;
			if (cmd_type === `CMD_PARAM)
				chk(cmd_data[3:0], 4'h5);
		end
	end
	initial begin
		#1900000;
		fails = fails + 1;
		end_sim;
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		srst <= 1'b0;
		wr(`REG_CTRL, 32'h1);
		rchk(`REG_CTRL, 32'h7, 32'h1);
		chk(offline_active, 1'b1);
		rchk(`REG_STATUS, 32'h3f, 32'h1);
		rchk(6'h3c, 32'hffffffff, 32'h0);
		wr(`REG_LDS_LO, 32'hffffffff);
		rchk(`REG_LDS_LO, 32'hffffffff, 32'h0);
		chk(ncmd, 0);
		wr(`REG_ACT_PARAM, 32'h5);
		wr(`REG_SEL, 32'h1);
		wr(`REG_PROJ, 32'h0);
		asi_slave_model_inst.present = 64'h0000_0002_0000_0022;
		wr(`REG_CTRL, 32'h6);
		poll(`REG_LDS_HI, 32'hffffffff, 32'h2);
		rchk(`REG_LDS_LO, 32'hffffffff, 32'h22);
		poll(`REG_LAS_HI, 32'hffffffff, 32'h2);
		rchk(`REG_LAS_LO, 32'hffffffff, 32'h22);
		wr(`REG_SEL, 32'h5);
		rchk(`REG_READBACK, 32'hffff, 32'h0167);
		slow <= 1'b0;
		asi_slave_model_inst.present[5] = 1'b0;
		poll(`REG_LDS_LO, 32'hffffffff, 32'h2);
		rchk(`REG_LAS_LO, 32'hffffffff, 32'h2);
		rchk(`REG_IN_IMG, 32'hf, 32'h0);
		// A fresh slave at 0 must land on the lowest free index, 2
		asi_slave_model_inst.present[0] = 1'b1;
		poll(`REG_LDS_LO, 32'hffffffff, 32'h6);
		poll(`REG_LAS_LO, 32'hffffffff, 32'h6);
		// Host moves the slave at 1B over to 2B
		wr(`REG_HOST_CMD, 32'h2221);
		poll(`REG_STATUS, 32'h600, 32'h400);
		wr(`REG_SEL, 32'h1);
		wr(`REG_OUT_IMG, 32'h0);
		rchk(`REG_OUT_IMG, 32'hf, 32'h0);
		wr(`REG_CTRL, 32'h7);
		poll(`REG_STATUS, 32'h3f, 32'h1);
		snap = ncmd;
		repeat (50) @(posedge sys_clk);
		rchk(`REG_OUT_IMG, 32'hf, 32'hf);
		rchk(`REG_IN_IMG, 32'hf, 32'h0);
		chk(ncmd, snap);
		// Slave 1 matches its enabled I/O id, slave 2 does not
		wr(`REG_PROJ, 32'h83);
		wr(`REG_SEL, 32'h2);
		wr(`REG_PROJ, 32'h85);
		wr(`REG_LPS_LO, 32'h7);
		rchk(`REG_LPS_LO, 32'hffffffff, 32'h6);
		wr(`REG_LPS_HI, 32'h1);
		rchk(`REG_LPS_HI, 32'hffffffff, 32'h0);
		wr(`REG_SEL, 32'h1);
		wr(`REG_CTRL, 32'h4);
		poll(`REG_LDS_HI, 32'hffffffff, 32'h4);
		poll(`REG_LAS_LO, 32'hffffffff, 32'h2);
		poll(`REG_IN_IMG, 32'hf, 32'h1);
		rchk(`REG_LAS_LO, 32'hffffffff, 32'h2);
		rchk(`REG_LAS_HI, 32'hffffffff, 32'h0);
		poll(`REG_STATUS, 32'h100, 32'h100);
		chk(config_fault, 1'b1);
		wr(`REG_CTRL, 32'h6);
		repeat (10) @(posedge sys_clk);
		#1 chk(config_fault, 1'b0);
		end_sim;
	end
endmodule // asi_phase_sequencer_tb
